// file: src/msf_pkg.sv
// constants for the motion sensor filter configuration block
// assumes a single 10 MHz clock and a byte-wide internal register port
package msf_pkg;

    // register offsets
    localparam logic [7:0] GYRO_SETUP_ADDR = 8'h1b;
    localparam logic [7:0] ACCEL_SETUP_ADDR = 8'h1c;
    localparam logic [7:0] ACCEL_SETUP_SECOND_ADDR = 8'h1d;

    // reset values
    localparam logic [7:0] GYRO_SETUP_RST = 8'h00;
    localparam logic [7:0] ACCEL_SETUP_RST = 8'h00;
    localparam logic [7:0] ACCEL_SETUP_SECOND_RST = 8'h00;

    // writable bits; everything else is reserved and reads zero
    localparam logic [7:0] GYRO_SETUP_MASK = 8'hfb;
    localparam logic [7:0] ACCEL_SETUP_MASK = 8'hf8;
    localparam logic [7:0] ACCEL_SETUP_SECOND_MASK = 8'hff;

    // field positions
    localparam int SELFTEST_X_BIT = 7;
    localparam int SELFTEST_Y_BIT = 6;
    localparam int SELFTEST_Z_BIT = 5;
    localparam int RANGE_LSB = 3;
    localparam int GYRO_BYPASS_LSB = 0;
    localparam int FIFO_SIZE_LSB = 6;
    localparam int WAKE_AVG_LSB = 4;
    localparam int ACCEL_BYPASS_BIT = 3;
    localparam int ACCEL_LP_LSB = 0;

    // decoded values at code 0; each further code doubles
    localparam logic [4:0] ACCEL_RANGE_G_BASE = 5'h02;
    localparam logic [12:0] FIFO_BYTES_BASE = 13'h0200;
    localparam logic [5:0] WAKE_AVG_BASE = 6'h04;
    localparam logic [11:0] GYRO_DPS_250 = 12'h0fa;
    localparam logic [11:0] GYRO_DPS_500 = 12'h1f4;
    localparam logic [11:0] GYRO_DPS_1000 = 12'h3e8;
    localparam logic [11:0] GYRO_DPS_2000 = 12'h7d0;

    // accel 3 dB bandwidth in tenths of Hz
    localparam logic [13:0] ACCEL_BW_BYPASS_DHZ = 14'h28dc;
    localparam logic [13:0] ACCEL_BW_DHZ [8] = '{14'h0885, 14'h0885, 14'h03de, 14'h01c0,
                                                 14'h00d4, 14'h0066, 14'h0033, 14'h1068};

    // wake rate codes
    localparam logic [3:0] WAKE_RATE_MIN = 4'h4;
    localparam logic [3:0] WAKE_RATE_MAX = 4'hb;

    // timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int ACCEL_RATE_HZ = 1000;
    localparam int ACCEL_FAST_RATE_HZ = 4000;
    localparam int WAKE_TOP_RATE_HZ = 500;
    localparam int TON_BYPASS_NS = 1084000;
    localparam int TON_AVG4_NS = 1840000;
    localparam int TON_AVG8_NS = 2840000;
    localparam int TON_AVG16_NS = 4840000;
    localparam int TON_AVG32_NS = 8840000;

    localparam int ACCEL_TICK_CYC = 1000000000 / (ACCEL_RATE_HZ * CLK_PERIOD_NS);
    localparam int ACCEL_FAST_CYC = 1000000000 / (ACCEL_FAST_RATE_HZ * CLK_PERIOD_NS);
    localparam int WAKE_BASE_CYC = 1000000000 / (WAKE_TOP_RATE_HZ * CLK_PERIOD_NS);
    localparam int TON_BYPASS_CYC = (TON_BYPASS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TON_AVG4_CYC = (TON_AVG4_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TON_AVG8_CYC = (TON_AVG8_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TON_AVG16_CYC = (TON_AVG16_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TON_AVG32_CYC = (TON_AVG32_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int PERIOD_W = 24;
    localparam int TON_W = 17;

    typedef enum logic [1:0] {
        MSF_GYRO_LOWPASS,
        MSF_GYRO_WIDE,
        MSF_GYRO_WIDEST
    } msf_gyro_path_e;

endpackage

// file: src/msf_tick_gen.sv
// free-running period divider giving one-cycle enable pulses
// assumes period is at least 1 and comes from the same clock
`timescale 1ns/100ps
`default_nettype none
module msf_tick_gen
    import msf_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic run,
    input wire logic [PERIOD_W-1:0] period,
    output logic tick
);

    logic [PERIOD_W-1:0] cnt_q;
    logic [PERIOD_W-1:0] cnt_d;
    wire logic at_end;

    // >= so that a shortened period never lets the count run away
    assign at_end = (cnt_q >= period - {{(PERIOD_W-1){1'b0}}, 1'b1});
    assign tick = run && at_end;
    assign cnt_d = (!run || at_end) ? '0 : cnt_q + {{(PERIOD_W-1){1'b0}}, 1'b1};

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

endmodule // msf_tick_gen
`default_nettype wire

// file: src/msf_config_regs.sv
// gyro/accel setup registers with rate, filter and wake-on-motion timing
// assumes the serial front end drives the register port on clk
// What this block does
// R01 - gyro range code selects 250 to 2000 dps
// R02 - gyro bypass bits choose lowpass or wide paths
// R03 - accel range code selects 2g to 16g
// R04 - fifo size code gives 512 B to 4 kB
// R05 - wake averaging code gives 4 to 32 samples
// R06 - accel bypass: no filter, 4 kHz, 1046 Hz
// R07 - accel lowpass code picks bandwidth at 1 kHz
// R08 - output rate divided by one plus divider
// R09 - wake mode duty-cycles the accelerometer
// R10 - host turns gyro off, sets cycle bit
// R11 - wake on-time from bypass or averaging code
// R12 - gyro lowpass only when bypass field zero
// R13 - wake rate codes 4..11, others reserved
// R14 - per-axis self-test bits at 7:5
// R15 - reserved bits read zero, writes ignored
`timescale 1ns/100ps
`default_nettype none
module msf_config_regs
    import msf_pkg::*;
#(
    parameter int ACCEL_TICK_CYCLES = ACCEL_TICK_CYC,
    parameter int WAKE_BASE_CYCLES = WAKE_BASE_CYC,
    parameter int TON_BYPASS_CYCLES = TON_BYPASS_CYC,
    parameter int TON_AVG4_CYCLES = TON_AVG4_CYC,
    parameter int TON_AVG8_CYCLES = TON_AVG8_CYC,
    parameter int TON_AVG16_CYCLES = TON_AVG16_CYC,
    parameter int TON_AVG32_CYCLES = TON_AVG32_CYC
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic [7:0] rate_divider,
    input wire logic [3:0] wake_rate_code,
    input wire logic gyro_off,
    input wire logic accel_cycle,
    output logic [2:0] gyro_selftest,
    output logic [2:0] accel_selftest,
    output logic [11:0] gyro_range_dps,
    output logic [4:0] accel_range_g,
    output logic [12:0] fifo_size_bytes,
    output logic [5:0] wake_avg_samples,
    output logic gyro_lowpass_on,
    output msf_gyro_path_e gyro_filter_path,
    output logic accel_lowpass_on,
    output logic [13:0] accel_bw_dhz,
    output logic accel_sample_tick,
    output logic odr_strobe,
    output logic wake_on_motion,
    output logic wake_rate_reserved,
    output logic accel_power_on
);

    logic [7:0] gyro_setup_q;
    logic [7:0] accel_setup_q;
    logic [7:0] accel_setup_second_q;
    logic [7:0] rdata_q;
    logic rvalid_q;
    logic [7:0] div_cnt_q;
    logic [7:0] div_cnt_d;
    logic duty_q;
    logic [TON_W-1:0] on_cnt_q;
    logic [TON_W-1:0] on_cnt_d;
    logic [7:0] rdata_d;

    wire logic sel_gyro;
    wire logic sel_accel;
    wire logic sel_accel2;
    wire logic [1:0] gyro_range_code;
    wire logic [1:0] gyro_filter_bypass;
    wire logic [1:0] accel_range_code;
    wire logic [1:0] fifo_size_code;
    wire logic [1:0] wake_averaging_code;
    wire logic accel_filter_bypass;
    wire logic [2:0] accel_lowpass_code;
    wire logic [PERIOD_W-1:0] accel_period;
    wire logic [PERIOD_W-1:0] wake_period;
    wire logic [TON_W-1:0] ton_len;
    wire logic [TON_W-1:0] ton_avg [4];
    wire logic wake_rate_ok;
    wire logic wake_tick;
    wire logic odr_hit;

    // register port decode
    assign sel_gyro = (reg_addr == GYRO_SETUP_ADDR);
    assign sel_accel = (reg_addr == ACCEL_SETUP_ADDR);
    assign sel_accel2 = (reg_addr == ACCEL_SETUP_SECOND_ADDR);

    // masked read mux; unmapped offsets read zero
    assign rdata_d = sel_gyro ? (gyro_setup_q & GYRO_SETUP_MASK) :   // R15
                     sel_accel ? (accel_setup_q & ACCEL_SETUP_MASK) :   // R15
                     sel_accel2 ? accel_setup_second_q : 8'h00;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            gyro_setup_q <= GYRO_SETUP_RST;
            accel_setup_q <= ACCEL_SETUP_RST;
            accel_setup_second_q <= ACCEL_SETUP_SECOND_RST;
        end else if (reg_wr) begin
            // reserved bits are never stored
            if (sel_gyro) gyro_setup_q <= reg_wdata & GYRO_SETUP_MASK; // R15
            if (sel_accel) accel_setup_q <= reg_wdata & ACCEL_SETUP_MASK; // R15
            if (sel_accel2) accel_setup_second_q <= reg_wdata & ACCEL_SETUP_SECOND_MASK;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= reg_rd;
            if (reg_rd) rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign reg_rvalid = rvalid_q;

    // field extraction
    assign gyro_range_code = gyro_setup_q[RANGE_LSB +: 2];
    assign gyro_filter_bypass = gyro_setup_q[GYRO_BYPASS_LSB +: 2];
    assign accel_range_code = accel_setup_q[RANGE_LSB +: 2];
    assign fifo_size_code = accel_setup_second_q[FIFO_SIZE_LSB +: 2];
    assign wake_averaging_code = accel_setup_second_q[WAKE_AVG_LSB +: 2];
    assign accel_filter_bypass = accel_setup_second_q[ACCEL_BYPASS_BIT];
    assign accel_lowpass_code = accel_setup_second_q[ACCEL_LP_LSB +: 3];

    assign gyro_selftest = {gyro_setup_q[SELFTEST_X_BIT], gyro_setup_q[SELFTEST_Y_BIT],   // R14
                            gyro_setup_q[SELFTEST_Z_BIT]};
    assign accel_selftest = {accel_setup_q[SELFTEST_X_BIT], accel_setup_q[SELFTEST_Y_BIT],   // R14
                             accel_setup_q[SELFTEST_Z_BIT]};

    assign gyro_range_dps = (gyro_range_code == 2'h0) ? GYRO_DPS_250 :   // R01
                            (gyro_range_code == 2'h1) ? GYRO_DPS_500 :
                            (gyro_range_code == 2'h2) ? GYRO_DPS_1000 : GYRO_DPS_2000;
    assign accel_range_g = ACCEL_RANGE_G_BASE << accel_range_code; // R03
    assign fifo_size_bytes = FIFO_BYTES_BASE << fifo_size_code; // R04
    assign wake_avg_samples = WAKE_AVG_BASE << wake_averaging_code; // R05

    // gyro path: bit 0 wins over bit 1, giving the widest band
    assign gyro_lowpass_on = (gyro_filter_bypass == 2'b00); // R12
    assign gyro_filter_path = gyro_filter_bypass[0] ? MSF_GYRO_WIDEST :   // R02
                              gyro_filter_bypass[1] ? MSF_GYRO_WIDE : MSF_GYRO_LOWPASS;

    // accel filter and base rate
    assign accel_lowpass_on = !accel_filter_bypass; // R06
    assign accel_bw_dhz = accel_filter_bypass ? ACCEL_BW_BYPASS_DHZ :   // R06
                          ACCEL_BW_DHZ[accel_lowpass_code]; // R07
    assign accel_period = accel_filter_bypass ? PERIOD_W'(ACCEL_FAST_CYC) :   // R06
                          PERIOD_W'(ACCEL_TICK_CYCLES); // R07

    // wake-on-motion entry is the host's job via the power control register
    assign wake_on_motion = gyro_off && accel_cycle; // R10
    assign wake_rate_ok = (wake_rate_code >= WAKE_RATE_MIN) && (wake_rate_code <= WAKE_RATE_MAX); // R13
    assign wake_rate_reserved = wake_on_motion && !wake_rate_ok; // R13
    // code 11 is the fastest rate; each lower code halves it
    assign wake_period = PERIOD_W'(WAKE_BASE_CYCLES) << (WAKE_RATE_MAX - wake_rate_code); // R13

    assign ton_avg[0] = TON_W'(TON_AVG4_CYCLES);
    assign ton_avg[1] = TON_W'(TON_AVG8_CYCLES);
    assign ton_avg[2] = TON_W'(TON_AVG16_CYCLES);
    assign ton_avg[3] = TON_W'(TON_AVG32_CYCLES);
    assign ton_len = accel_filter_bypass ? TON_W'(TON_BYPASS_CYCLES) :   // R11
                     ton_avg[wake_averaging_code]; // R11

    msf_tick_gen u_accel_tick (
        .clk(clk),
        .resetn(resetn),
        .run(!wake_on_motion),
        .period(accel_period),
        .tick(accel_sample_tick)
    );

    msf_tick_gen u_wake_tick (
        .clk(clk),
        .resetn(resetn),
        .run(wake_on_motion && wake_rate_ok),
        .period(wake_period),
        .tick(wake_tick)
    );

    // output rate divider over filter samples
    assign odr_hit = accel_sample_tick && (div_cnt_q >= rate_divider); // R08
    assign div_cnt_d = wake_on_motion ? 8'h00 :
                       odr_hit ? 8'h00 :
                       accel_sample_tick ? div_cnt_q + 8'h01 : div_cnt_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            div_cnt_q <= 8'h00;
        end else begin
            div_cnt_q <= div_cnt_d; // R08
        end
    end

    // duty cycle: on for ton_len cycles from each wake period start
    assign on_cnt_d = wake_tick ? ton_len - {{(TON_W-1){1'b0}}, 1'b1} :   // R09
                      (on_cnt_q != '0) ? on_cnt_q - {{(TON_W-1){1'b0}}, 1'b1} : on_cnt_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            duty_q <= 1'b0;
            on_cnt_q <= '0;
        end else if (!wake_on_motion || !wake_rate_ok) begin
            duty_q <= 1'b0;
            on_cnt_q <= '0;
        end else begin
            on_cnt_q <= on_cnt_d;
            if (wake_tick) duty_q <= 1'b1; // R09
            else if (on_cnt_q == '0) duty_q <= 1'b0; // R11
        end
    end

    // in wake mode a sample is ready when the on-time ends
    assign odr_strobe = wake_on_motion ? (duty_q && on_cnt_q == '0 && !wake_tick) : odr_hit;
    assign accel_power_on = wake_on_motion ? duty_q : 1'b1; // R09

    // checks
    logic [PERIOD_W-1:0] gap_q;
    logic [8:0] ticks_q;
    logic [TON_W:0] on_len_q;
    logic [TON_W-1:0] ton_cap_q;
    logic byp_q;
    logic [7:0] div_prev_q;

    // all ones marks a span cut by a mode or setting change; such spans are not measured
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            gap_q <= '0;
            ticks_q <= '0;
            on_len_q <= '0;
            ton_cap_q <= '0;
            byp_q <= 1'b0;
            div_prev_q <= 8'h00;
        end else begin
            byp_q <= accel_filter_bypass;
            div_prev_q <= rate_divider;
            if (wake_tick) ton_cap_q <= ton_len;
            gap_q <= accel_sample_tick ? '0 :
                     (wake_on_motion || byp_q != accel_filter_bypass || gap_q == '1) ? '1 :
                     gap_q + 24'h000001;
            ticks_q <= (odr_strobe || wake_on_motion) ? 9'h000 :
                       (div_prev_q != rate_divider || ticks_q == 9'h1ff) ? 9'h1ff :
                       ticks_q + {8'h00, accel_sample_tick};
            on_len_q <= duty_q ? on_len_q + 18'h00001 : '0;
        end
    end

    sequence seq_wake_start;
        wake_on_motion && wake_rate_ok && wake_tick;
    endsequence

    sequence seq_awake;
        duty_q && accel_power_on;
    endsequence

    AST_GYRO_RANGE: assert property (@(posedge clk) disable iff (!resetn) // R01
        reg_wr && sel_gyro |=> gyro_range_code == $past(reg_wdata[4:3]) &&
        (gyro_range_dps == (gyro_range_code[1] ? (gyro_range_code[0] ? 12'h7d0 : 12'h3e8) :
                            (gyro_range_code[0] ? 12'h1f4 : 12'h0fa))))
        else $error("gyro range not taken from write");
    AST_GYRO_PATH: assert property (@(posedge clk) disable iff (!resetn) // R02
        reg_wr && sel_gyro && reg_wdata[1:0] == 2'b10 |=> gyro_filter_path == MSF_GYRO_WIDE)
        else $error("gyro bypass path wrong");
    AST_GYRO_LP: assert property (@(posedge clk) disable iff (!resetn) // R12
        gyro_lowpass_on |-> gyro_filter_path == MSF_GYRO_LOWPASS && gyro_setup_q[1:0] == 2'b00)
        else $error("gyro lowpass with bypass set");
    AST_ACCEL_RANGE: assert property (@(posedge clk) disable iff (!resetn) // R03
        reg_wr && sel_accel && reg_wdata[4:3] == 2'b11 |=> accel_range_g == 5'h10)
        else $error("accel range 16g not selected");
    AST_FIFO_SIZE: assert property (@(posedge clk) disable iff (!resetn) // R04
        reg_wr && sel_accel2 && reg_wdata[7:6] == 2'b11 |=> fifo_size_bytes == 13'h1000)
        else $error("fifo size 4k not selected");
    AST_WAKE_AVG: assert property (@(posedge clk) disable iff (!resetn) // R05
        reg_wr && sel_accel2 |=> wake_avg_samples == (6'h04 << $past(reg_wdata[5:4])))
        else $error("wake averaging count wrong");
    AST_FAST_RATE: assert property (@(posedge clk) disable iff (!resetn) // R06
        accel_sample_tick && accel_filter_bypass && $past(accel_filter_bypass) && gap_q != '0 && gap_q != '1 |->
        gap_q == PERIOD_W'(ACCEL_FAST_CYC - 1) && accel_bw_dhz == 14'h28dc)
        else $error("bypass sample spacing wrong");
    AST_LP_RATE: assert property (@(posedge clk) disable iff (!resetn) // R07
        accel_sample_tick && !accel_filter_bypass && !$past(accel_filter_bypass) && gap_q != '0 && gap_q != '1 |->
        gap_q == PERIOD_W'(ACCEL_TICK_CYCLES - 1))
        else $error("lowpass sample spacing wrong");
    AST_ODR_DIV: assert property (@(posedge clk) disable iff (!resetn) // R08
        odr_strobe && !wake_on_motion && $stable(rate_divider) && ticks_q != '0 && ticks_q != 9'h1ff |->
        ticks_q == {1'b0, rate_divider})
        else $error("output rate not divided by divider plus one");
    AST_WAKE_ON: assert property (@(posedge clk) disable iff (!resetn) // R09
        seq_wake_start |=> seq_awake ##1 seq_awake)
        else $error("accelerometer not powered at wake period start");
    AST_WAKE_TON: assert property (@(posedge clk) disable iff (!resetn) // R11
        wake_on_motion && wake_rate_ok && $fell(duty_q) && !$past(wake_tick) |->
        on_len_q == {1'b0, ton_cap_q})
        else $error("wake on-time length wrong");
    AST_WAKE_RSVD: assert property (@(posedge clk) disable iff (!resetn) // R13
        wake_rate_reserved |=> !duty_q || !$past(wake_rate_reserved))
        else $error("reserved wake rate ran the accelerometer");
    AST_SELFTEST: assert property (@(posedge clk) disable iff (!resetn) // R14
        reg_wr && sel_accel |=> accel_selftest == $past(reg_wdata[7:5]))
        else $error("self-test bits not taken");
    AST_RSVD_READ: assert property (@(posedge clk) disable iff (!resetn) // R15
        reg_rd && sel_accel |=> reg_rvalid && reg_rdata[2:0] == 3'h0)
        else $error("reserved bits read nonzero");

endmodule // msf_config_regs
`default_nettype wire

// file: tb/msf_host_model.sv
// host side of the register port: byte writes, byte reads, power and rate inputs
// assumes one clock; every request is driven 1 ns after a rising edge
`timescale 1ns/100ps
`default_nettype none
module msf_host_model (
    input wire logic clk,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    output logic [7:0] rate_divider,
    output logic [3:0] wake_rate_code,
    output logic gyro_off,
    output logic accel_cycle
);
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
        rate_divider = 8'h00;
        wake_rate_code = 4'hb;
        gyro_off = 1'b0;
        accel_cycle = 1'b0;
    end

    // released lines show the inverse so stale values never look valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
        @(negedge clk);
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk);
        #1;
        reg_rd = 1'b0;
        reg_addr = ~a;
        @(negedge clk);
        d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
    endtask

    task automatic ctl(input logic [7:0] div, input logic [3:0] code, input logic goff, input logic cyc);
        @(posedge clk);
        #1;
        rate_divider = div;
        wake_rate_code = code;
        gyro_off = goff;
        accel_cycle = cyc;
        @(negedge clk);
    endtask
endmodule // msf_host_model
`default_nettype wire

// file: tb/msf_config_regs_tb_top.sv
// self-checking bench for the setup register group and its rate/duty outputs
// assumes shortened tick, wake period and on-time parameters set below
`timescale 1ns/100ps
`default_nettype none
module msf_config_regs_tb_top
    import msf_pkg::*;
;
    logic clk, resetn, reg_wr, reg_rd, reg_rvalid, gyro_off, accel_cycle;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rate_divider;
    logic [3:0] wake_rate_code;
    logic [2:0] gyro_selftest, accel_selftest;
    logic [11:0] gyro_range_dps;
    logic [4:0] accel_range_g;
    logic [12:0] fifo_size_bytes;
    logic [5:0] wake_avg_samples;
    logic [13:0] accel_bw_dhz;
    logic gyro_lowpass_on, accel_lowpass_on, accel_sample_tick, odr_strobe;
    logic wake_on_motion, wake_rate_reserved, accel_power_on;
    msf_gyro_path_e gyro_filter_path;
    int num_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [15:0] dps [4] = '{16'h00fa, 16'h01f4, 16'h03e8, 16'h07d0};
    logic [15:0] bw [8] = '{16'h0885, 16'h0885, 16'h03de, 16'h01c0, 16'h00d4, 16'h0066, 16'h0033, 16'h1068};
    // shortened timing so the wake and duty paths fit the cycle budget
    localparam int TB_TICK = 40;
    localparam int TB_WAKE = 64;
    localparam int TB_TON_BYP = 5;
    localparam int TB_TON [4] = '{8, 11, 14, 17};
    logic [15:0] ton [4] = '{16'(TB_TON[0]), 16'(TB_TON[1]), 16'(TB_TON[2]), 16'(TB_TON[3])};
    logic [3:0] rsv [4] = '{4'h0, 4'h3, 4'hc, 4'hf};

    msf_config_regs #(.ACCEL_TICK_CYCLES(TB_TICK), .WAKE_BASE_CYCLES(TB_WAKE), .TON_BYPASS_CYCLES(TB_TON_BYP),
        .TON_AVG4_CYCLES(TB_TON[0]), .TON_AVG8_CYCLES(TB_TON[1]), .TON_AVG16_CYCLES(TB_TON[2]),
        .TON_AVG32_CYCLES(TB_TON[3])) uut (
        .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .rate_divider(rate_divider),
        .wake_rate_code(wake_rate_code), .gyro_off(gyro_off), .accel_cycle(accel_cycle),
        .gyro_selftest(gyro_selftest), .accel_selftest(accel_selftest), .gyro_range_dps(gyro_range_dps),
        .accel_range_g(accel_range_g), .fifo_size_bytes(fifo_size_bytes), .wake_avg_samples(wake_avg_samples),
        .gyro_lowpass_on(gyro_lowpass_on), .gyro_filter_path(gyro_filter_path),
        .accel_lowpass_on(accel_lowpass_on), .accel_bw_dhz(accel_bw_dhz),
        .accel_sample_tick(accel_sample_tick), .odr_strobe(odr_strobe), .wake_on_motion(wake_on_motion),
        .wake_rate_reserved(wake_rate_reserved), .accel_power_on(accel_power_on));

    msf_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .rate_divider(rate_divider),
        .wake_rate_code(wake_rate_code), .gyro_off(gyro_off), .accel_cycle(accel_cycle));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic give_verdict;
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 50000) begin
            num_errors++;
            give_verdict();
        end
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic sig(input int s);
        case (s)
            0: return accel_sample_tick;
            1: return odr_strobe;
            default: return accel_power_on;
        endcase
    endfunction

    // cycles until the next low-to-high change; bounded so a dead output cannot hang
    task automatic to_rise(input int s, output int n);
        logic p;
        p = sig(s);
        n = 0;
        do begin
            @(negedge clk);
            n++;
            if (sig(s) === 1'b1 && p !== 1'b1) break;
            p = sig(s);
        end while (n < 20000);
    endtask

    task automatic on_len(output int n, output logic last_odr);
        to_rise(2, n);
        n = 0;
        last_odr = 1'b0;
        while (accel_power_on === 1'b1 && n < 1000) begin
            n++;
            last_odr = odr_strobe;
            @(negedge clk);
        end
    endtask

    task automatic count_hi(input int s, input int cyc, output int n);
        n = 0;
        repeat (cyc) begin
            @(negedge clk);
            if (sig(s) === 1'b1) n++;
        end
    endtask

    initial begin
        logic [7:0] d;
        logic lo;
        int n, i;
        resetn = 1'b0;
        repeat (5) @(posedge clk);
        #1;
        resetn = 1'b1;
        for (i = 0; i < 3; i++) begin
            host.rd(8'(8'h1b + i), d);
            check("reset value", d, 8'h00);
        end
        for (i = 0; i < 4; i++) begin
            host.wr(8'h1b, 8'(i << 3));
            check("gyro range", gyro_range_dps, dps[i]);
            host.wr(8'h1c, 8'(i << 3));
            check("accel range", accel_range_g, 16'h0002 << i);
            host.wr(8'h1d, 8'((i << 6) | (i << 4)));
            check("fifo size", fifo_size_bytes, 16'h0200 << i);
            check("wake avg", wake_avg_samples, 16'h0004 << i);
            host.wr(8'h1b, 8'(i));
            check("gyro lowpass", gyro_lowpass_on, i == 0);
            check("gyro path", gyro_filter_path, i % 2 ? 2 : (i == 2 ? 1 : 0));
        end
        for (i = 0; i < 8; i++) begin
            host.wr(8'h1d, 8'(i));
            check("accel bw", accel_bw_dhz, bw[i]);
            check("accel lowpass", accel_lowpass_on, 1);
        end
        host.wr(8'h1b, 8'ha0);
        check("gyro selftest", gyro_selftest, 3'b101);
        host.wr(8'h1c, 8'h40);
        check("accel selftest", accel_selftest, 3'b010);
        host.wr(8'h1b, 8'hff);
        host.wr(8'h1c, 8'hff);
        host.wr(8'h1e, 8'h55);
        host.rd(8'h1b, d);
        check("gyro reserved", d, 8'hfb);
        host.rd(8'h1c, d);
        check("accel reserved", d, 8'hf8);
        host.rd(8'h1e, d);
        check("unmapped read", d, 8'h00);
        host.wr(8'h1d, 8'h00);
        to_rise(0, n);
        to_rise(0, n);
        check("tick gap", n, TB_TICK);
        host.ctl(8'h03, 4'hb, 1'b0, 1'b0);
        to_rise(1, n);
        to_rise(1, n);
        check("odr gap", n, 4 * TB_TICK);
        check("odr on tick", accel_sample_tick, 1);
        host.wr(8'h1d, 8'h08);
        check("bypass bw", accel_bw_dhz, 16'h28dc);
        check("bypass lowpass", accel_lowpass_on, 0);
        to_rise(0, n);
        to_rise(0, n);
        check("bypass tick gap", n, 2500);
        host.ctl(8'h03, 4'hb, 1'b1, 1'b1);
        check("wake mode", wake_on_motion, 1);
        on_len(n, lo);
        check("bypass on time", n, TB_TON_BYP);
        check("odr at on end", lo, 1);
        to_rise(2, n);
        to_rise(2, n);
        check("wake period 11", n, TB_WAKE);
        count_hi(0, 100, n);
        check("ticks in wake", n, 0);
        for (i = 0; i < 4; i++) begin
            host.wr(8'h1d, 8'((i << 4) | 7));
            on_len(n, lo);
            check("avg on time", n, ton[i]);
        end
        host.ctl(8'h03, 4'ha, 1'b1, 1'b1);
        to_rise(2, n);
        to_rise(2, n);
        check("wake period 10", n, 2 * TB_WAKE);
        for (i = 0; i < 4; i++) begin
            host.ctl(8'h00, rsv[i], 1'b1, 1'b1);
            check("rate reserved", wake_rate_reserved, 1);
            count_hi(2, 150, n);
            check("no duty on reserved", n, 0);
        end
        host.ctl(8'h00, 4'h4, 1'b0, 1'b1);
        check("wake left", wake_on_motion, 0);
        check("power steady", accel_power_on, 1);
        give_verdict();
    end
endmodule // msf_config_regs_tb_top
`default_nettype wire
